// [shared/bsc_regs.svh]
`ifndef BSC_REGS_SVH
`define BSC_REGS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define BSC_INSTR_W 14
`define BSC_PC_W 13
`define BSC_DATA_W 8

// ----------------------------------------
// Opcode masks and patterns
// ----------------------------------------
`define BSC_SKIP_MASK 14'h3C00
`define BSC_SKIP_PAT 14'h1C00
`define BSC_CLR_MASK 14'h3F80
`define BSC_CLR_PAT 14'h0180
`define BSC_CALL_MASK 14'h3800
`define BSC_CALL_PAT 14'h2000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BSC_BIT_MSB 9
`define BSC_BIT_LSB 7
`define BSC_FADDR_MSB 6
`define BSC_K_MSB 10
`define BSC_LATCH_HI 4
`define BSC_LATCH_LO 3

// ----------------------------------------
// Values and cycle counts
// ----------------------------------------
`define BSC_CLR_VALUE 8'h00
`define BSC_PC_STEP 13'h0001
`define BSC_CYC_SHORT 1
`define BSC_CYC_LONG 2

`endif

// [shared/bsc_pkg.sv]
`include "bsc_regs.svh"

package bsc_pkg;

	// ----------------------------------------
	// Operation classes
	// ----------------------------------------
	typedef enum logic [1:0] {
		BSC_OP_OTHER = 2'b00,
		BSC_OP_SKIP = 2'b01,
		BSC_OP_CLR = 2'b10,
		BSC_OP_CALL = 2'b11
	} bsc_op_e;

	// ----------------------------------------
	// Execution states
	// ----------------------------------------
	typedef enum logic [1:0] {
		BSC_ST_FETCH = 2'b00,
		BSC_ST_EXEC = 2'b01,
		BSC_ST_FLUSH = 2'b10
	} bsc_state_e;

	// Decoded instruction fields
	typedef struct packed {
		bsc_op_e op;
		logic [2:0] bit_sel;
		logic [6:0] reg_addr;
		logic [10:0] target;
	} bsc_dec_s;

	// Register file access
	typedef struct packed {
		logic we;
		logic [6:0] addr;
		logic [7:0] wdata;
	} bsc_rf_s;

	// Return stack push
	typedef struct packed {
		logic push;
		logic [12:0] addr;
	} bsc_stk_s;

	// Fetch unit control
	typedef struct packed {
		logic load;
		logic flush;
		logic [12:0] target;
	} bsc_fch_s;

endpackage

// [design/bsc_decode.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bsc_regs.svh"

module bsc_decode
	import bsc_pkg::*;
(
	// Instruction word
	input wire logic [13:0] i_instr,
	// Decoded fields
	output var bsc_dec_s o_dec
);

	// ----------------------------------------
	// Pattern match
	// ----------------------------------------
	function automatic logic op_match(input logic [13:0] ins,
		input logic [13:0] mask, input logic [13:0] pat);
		op_match = ((ins & mask) == pat);
	endfunction

	// Classify and split fields
	always_comb begin
		o_dec.bit_sel = i_instr[`BSC_BIT_MSB:`BSC_BIT_LSB];
		o_dec.reg_addr = i_instr[`BSC_FADDR_MSB:0];
		o_dec.target = i_instr[`BSC_K_MSB:0];
		if (op_match(i_instr, `BSC_SKIP_MASK, `BSC_SKIP_PAT)) begin
			o_dec.op = BSC_OP_SKIP;
		end else if (op_match(i_instr, `BSC_CLR_MASK, `BSC_CLR_PAT)) begin
			o_dec.op = BSC_OP_CLR;
		end else if (op_match(i_instr, `BSC_CALL_MASK, `BSC_CALL_PAT)) begin
			o_dec.op = BSC_OP_CALL;
		end else begin
			o_dec.op = BSC_OP_OTHER;
		end
	end

endmodule
`default_nettype wire

// [design/bsc_exec.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bsc_regs.svh"

module bsc_exec
	import bsc_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Instruction from fetch
	input wire logic i_ins_valid,
	input wire logic [13:0] i_instr,
	input wire logic [12:0] i_pc,
	// Page latch and register read data
	input wire logic [7:0] i_pc_high_latch,
	input wire logic [7:0] i_rf_rdata,
	// Handshake and status
	output logic o_ready,
	output logic o_zero_set,
	// Register file, stack, fetch control
	output var bsc_rf_s o_rf,
	output var bsc_stk_s o_stk,
	output var bsc_fch_s o_fch
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	bsc_state_e state_r;
	bsc_state_e state_nxt;
	bsc_dec_s dec_r;
	bsc_dec_s dec_nxt;
	bsc_dec_s dec_w;
	logic [12:0] pc_r;
	logic [12:0] pc_nxt;
	logic ready_r;
	logic ready_nxt;
	logic zset_r;
	logic zset_nxt;
	bsc_rf_s rf_r;
	bsc_rf_s rf_nxt;
	bsc_stk_s stk_r;
	bsc_stk_s stk_nxt;
	bsc_fch_s fch_r;
	bsc_fch_s fch_nxt;
	logic bit_val;

	// Instruction decoder
	bsc_decode u_decode (
		.i_instr(i_instr),
		.o_dec(dec_w)
	);

	// Tested bit of the addressed register
	assign bit_val = i_rf_rdata[dec_r.bit_sel];

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		dec_nxt = dec_r;
		pc_nxt = pc_r;
		ready_nxt = ready_r;
		zset_nxt = 1'b0;
		rf_nxt = rf_r;
		rf_nxt.we = 1'b0;
		stk_nxt = stk_r;
		stk_nxt.push = 1'b0;
		fch_nxt = fch_r;
		fch_nxt.load = 1'b0;
		fch_nxt.flush = 1'b0;
		case (state_r)
			BSC_ST_FETCH: begin
				if (i_ins_valid && ready_r) begin
					dec_nxt = dec_w;
					pc_nxt = i_pc;
					rf_nxt.addr = dec_w.reg_addr;
					ready_nxt = 1'b0;
					state_nxt = BSC_ST_EXEC;
				end
			end
			BSC_ST_EXEC: begin
				case (dec_r.op)
					BSC_OP_SKIP: begin
						// No flag or register write here
						if (bit_val) begin
							fch_nxt.flush = 1'b1;
							state_nxt = BSC_ST_FLUSH;
						end else begin
							ready_nxt = 1'b1;
							state_nxt = BSC_ST_FETCH;
						end
					end
					BSC_OP_CLR: begin
						rf_nxt.we = 1'b1;
						rf_nxt.wdata = `BSC_CLR_VALUE;
						zset_nxt = 1'b1;
						ready_nxt = 1'b1;
						state_nxt = BSC_ST_FETCH;
					end
					BSC_OP_CALL: begin
						stk_nxt.push = 1'b1;
						stk_nxt.addr = pc_r + `BSC_PC_STEP;
						fch_nxt.load = 1'b1;
						fch_nxt.flush = 1'b1;
						fch_nxt.target = {i_pc_high_latch[`BSC_LATCH_HI:
							`BSC_LATCH_LO], dec_r.target};
						state_nxt = BSC_ST_FLUSH;
					end
					default: begin
						ready_nxt = 1'b1;
						state_nxt = BSC_ST_FETCH;
					end
				endcase
			end
			BSC_ST_FLUSH: begin
				// Dead cycle executes as a NOP
				ready_nxt = 1'b1;
				state_nxt = BSC_ST_FETCH;
			end
			default: begin
				ready_nxt = 1'b1;
				state_nxt = BSC_ST_FETCH;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_r <= BSC_ST_FETCH;
			dec_r <= '0;
			pc_r <= 13'h0000;
			ready_r <= 1'b1;
			zset_r <= 1'b0;
			rf_r <= '0;
			stk_r <= '0;
			fch_r <= '0;
		end else begin
			state_r <= state_nxt;
			dec_r <= dec_nxt;
			pc_r <= pc_nxt;
			ready_r <= ready_nxt;
			zset_r <= zset_nxt;
			rf_r <= rf_nxt;
			stk_r <= stk_nxt;
			fch_r <= fch_nxt;
		end
	end

	// Outputs straight from flops
	assign o_ready = ready_r;
	assign o_zero_set = zset_r;
	assign o_rf = rf_r;
	assign o_stk = stk_r;
	assign o_fch = fch_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	logic ex_skip;
	logic ex_clr;
	logic ex_call;
	assign ex_skip = (state_r == BSC_ST_EXEC) && (dec_r.op == BSC_OP_SKIP);
	assign ex_clr = (state_r == BSC_ST_EXEC) && (dec_r.op == BSC_OP_CLR);
	assign ex_call = (state_r == BSC_ST_EXEC) && (dec_r.op == BSC_OP_CALL);

	a_skip_taken_flush: assert property (
		ex_skip && bit_val |=> o_fch.flush && !o_ready ##1 o_ready)
		else $error("taken skip did not flush for two cycles");
	a_skip_not_taken: assert property (
		ex_skip && !bit_val |=> o_ready && !o_fch.flush)
		else $error("untaken skip was not one cycle");
	a_skip_flags_kept: assert property (
		ex_skip |=> !o_zero_set && !o_rf.we && !o_stk.push)
		else $error("skip changed flags or registers");
	a_clear_zero_write: assert property (
		ex_clr |=> o_rf.we && o_rf.wdata == `BSC_CLR_VALUE && o_zero_set
			&& o_rf.addr == $past(dec_r.reg_addr) && o_ready)
		else $error("clear did not write zero and set zero flag");
	a_call_push_ret: assert property (
		ex_call |=> o_stk.push && o_stk.addr == $past(pc_r) + `BSC_PC_STEP)
		else $error("call pushed wrong return address");
	a_call_target_page: assert property (
		ex_call |=> o_fch.target == {$past(i_pc_high_latch[4:3]),
			$past(dec_r.target)})
		else $error("call target bits wrong");
	a_call_two_cycles: assert property (
		ex_call |=> !o_ready && !o_zero_set ##1 o_ready && !o_fch.load)
		else $error("call not two cycles or touched flags");
	a_call_flush_load: assert property (
		ex_call |=> o_fch.flush && o_fch.load && state_r == BSC_ST_FLUSH)
		else $error("call did not flush and redirect fetch");

	c_skip_taken: cover property (ex_skip && bit_val);
	c_skip_not_taken: cover property (ex_skip && !bit_val);
	c_clear: cover property (ex_clr);
	c_call: cover property (ex_call ##1 state_r == BSC_ST_FLUSH ##1 o_ready);

endmodule
`default_nettype wire

// [verif/bsc_rf_model.sv]
`timescale 1ns/1ps
`default_nettype none

module bsc_rf_model
	import bsc_pkg::*;
(
	// Clock
	input wire logic i_clk,
	// Register file access from the core
	input wire bsc_rf_s i_rf,
	// Read data back to the core
	output logic [7:0] o_rdata
);
	logic [7:0] mem [0:127];

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Known contents so no unknown reaches the core
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'(i);
		end
	end

	// Read is combinational on the held address
	assign o_rdata = mem[i_rf.addr];

	// Write on the strobe
	always @(posedge i_clk) begin
		if (i_rf.we === 1'b1) begin
			mem[i_rf.addr] <= i_rf.wdata;
		end
	end
endmodule

`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb;
	import bsc_pkg::*;
	localparam logic [38:0] MP = {5'h1F, 34'h0};
	localparam logic [38:0] MW = {5'h1F, 8'hFF, 26'h0};
	localparam logic [38:0] MC = {5'h1F, 8'h00, 26'h3FFFFFF};
	logic i_clk, i_rst, i_ins_valid, o_ready, o_zero_set;
	logic [13:0] i_instr;
	logic [12:0] i_pc, pc;
	logic [7:0] i_pc_high_latch, rdata, v, lat;
	logic [6:0] f;
	logic [2:0] b;
	logic [10:0] k;
	logic [38:0] e, m, obs;
	logic [38:0] exp_q[$];
	logic [38:0] msk_q[$];
	logic [31:0] seed = 32'hBBAD9F29;
	logic [13:0] oth [6] = '{14'h1000, 14'h1400, 14'h1800, 14'h0100,
		14'h2800, 14'h0000};
	bsc_rf_s o_rf;
	bsc_stk_s o_stk;
	bsc_fch_s o_fch;
	int fail_count, tests_run;

	bsc_exec bsc_exec_i(.i_clk(i_clk), .i_rst(i_rst),
		.i_ins_valid(i_ins_valid), .i_instr(i_instr), .i_pc(i_pc),
		.i_pc_high_latch(i_pc_high_latch), .i_rf_rdata(rdata),
		.o_ready(o_ready), .o_zero_set(o_zero_set), .o_rf(o_rf),
		.o_stk(o_stk), .o_fch(o_fch));
	bsc_rf_model bsc_rf_model_i(.i_clk(i_clk), .i_rf(o_rf), .o_rdata(rdata));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
	endfunction

	// Clock
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	task tally_and_finish;
		$display("checks %0d failures %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic note(input logic [38:0] ev, input logic [38:0] mv);
		exp_q.push_back(ev);
		msk_q.push_back(mv);
	endtask

	// Offer one word for one cycle, then count cycles to ready
	task automatic issue(input logic [13:0] ins, input logic [12:0] p,
		input logic [7:0] l, input int cyc);
		int n;
		@(posedge i_clk);
		i_ins_valid <= 1'b1;
		i_instr <= ins;
		i_pc <= p;
		i_pc_high_latch <= l;
		@(posedge i_clk);
		i_ins_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge i_clk);
			#1;
			n++;
		end while (o_ready !== 1'b1 && n < 8);
		`CHK(n, cyc)
	endtask

	// Every pulse consumes the oldest note
	always @(negedge i_clk) begin
		obs = {o_zero_set, o_rf.we, o_stk.push, o_fch.load, o_fch.flush,
			o_rf.wdata, o_stk.addr, o_fch.target};
		if (!i_rst && (|obs[38:34]) === 1'b1) begin
			if (exp_q.size() == 0) begin
				`CHK(obs[38:34], 5'h00)
			end else begin
				e = exp_q.pop_front();
				m = msk_q.pop_front();
				`CHK(obs & m, e & m)
			end
		end
	end

	// Watchdog
	initial begin
		repeat (3000) @(posedge i_clk);
		fail_count++;
		$display("watchdog expired");
		tally_and_finish;
	end

	// Main sequence
	initial begin
		i_rst = 1'b1;
		i_ins_valid = 1'b0;
		i_instr = 14'h0000;
		i_pc = 13'h0000;
		i_pc_high_latch = 8'h00;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		#1;
		`CHK({o_ready, o_zero_set, o_rf, o_stk, o_fch}, {1'b1, 46'h0})
		// Clear a full register, then a skip on any bit of it stays short
		for (int i = 0; i < 4; i++) begin
			f = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : seed[6:0];
			b = seed[9:7];
			seed = lfsr(seed);
			bsc_rf_model_i.mem[f] = 8'hFF;
			note({5'b11000, 34'h0}, MW);
			issue({7'b0000011, f}, 13'h0000, 8'h00, 1);
			issue({4'b0111, b, f}, 13'h0000, 8'h00, 1);
			`CHK(bsc_rf_model_i.mem[f], 8'h00)
		end
		$display("test clear done");
		// Skip on random bits of random contents
		for (int i = 0; i < 16; i++) begin
			f = seed[6:0];
			b = seed[9:7];
			v = seed[17:10];
			seed = lfsr(seed);
			bsc_rf_model_i.mem[f] = v;
			if (v[b]) begin
				note({5'b00001, 34'h0}, MP);
			end
			issue({4'b0111, b, f}, 13'h0000, 8'h00, v[b] ? 2 : 1);
		end
		$display("test skip done");
		// Call with edge targets and random page bits
		for (int i = 0; i < 4; i++) begin
			k = (i == 0) ? 11'h000 : (i == 1) ? 11'h7FF : seed[10:0];
			pc = (i == 1) ? 13'h1FFF : seed[31:19];
			lat = seed[27:20];
			seed = lfsr(seed);
			note({5'b00111, 8'h00, pc + 13'h0001, lat[4:3], k}, MC);
			issue({3'b100, k}, pc, lat, 2);
		end
		$display("test call done");
		// Neighbouring opcodes give no outputs
		foreach (oth[i]) begin
			issue(oth[i], 13'h0000, 8'h00, 1);
		end
		repeat (4) @(posedge i_clk);
		`CHK(exp_q.size(), 0)
		$display("test other done");
		tally_and_finish;
	end
endmodule

`default_nettype wire
